// ===== src/spcfg_defs.svh
// Constants for the serial configuration register block.
// Included by the package and the design; definitions only.
`ifndef SPCFG_DEFS_SVH
`define SPCFG_DEFS_SVH
`define SPCFG_ADDR_GATE 2'h0
`define SPCFG_ADDR_MODE 2'h1
`define SPCFG_ADDR_RETRY 2'h2
`define SPCFG_ADDR_MASK 2'h3
`define SPCFG_BIT_ZERO 15
`define SPCFG_BIT_NULL 14
`define SPCFG_ADDR_HI 13
`define SPCFG_ADDR_LO 12
`define SPCFG_DATA_HI 5
`define SPCFG_REG_RESET 6'h00
`define SPCFG_REPLY_PAD 4'h0
`define SPCFG_FRAME_BITS 16
`endif

// ===== src/spcfg_pkg.sv
// Types shared by the serial configuration register block.
// Assumes spcfg_defs.svh is on the include path.
`include "spcfg_defs.svh"
package spcfg_pkg;
    typedef enum logic [1:0] {
        SPCFG_IDLE = 2'b01,
        SPCFG_SHIFT = 2'b10
    } spcfg_state_t;
    typedef struct packed {
        logic [5:0] latch_mode;
        logic retry_hi;
        logic retry_lo;
        logic [1:0] thresh_hi;
        logic [1:0] thresh_lo;
        logic [5:0] flag_mask;
    } spcfg_cfg_t;
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic sdi;
        logic ena_soft;
        logic ena_out;
        logic [5:0] par;
    } spcfg_pins_t;
endpackage

// ===== src/spcfg_regs.sv
// Serial-programmed configuration registers of a six-channel pre-driver,
// with the gate qualifier, flag logic and fault read-back shift path.
// Assumes fault detection logic on clk_in supplies fault codes and
// per-channel fault levels; the serial link pins are asynchronous.
`timescale 1ns/1ps
`include "spcfg_defs.svh"
module spcfg_regs
    import spcfg_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic chip_select_n_in,
    input wire logic sclk_in,
    input wire logic sdi_in,
    input wire logic soft_reset_enable_in,
    input wire logic output_enable_in,
    input wire logic [5:0] parallel_in,
    input wire logic [5:0] shorted_load_state_in,
    input wire logic [5:0] drain_feedback_in,
    input wire logic [5:0] fault_detect_in,
    input wire logic [11:0] fault_code_in,
    output logic [5:0] gate_drive_out,
    output spcfg_cfg_t config_out,
    output logic cmd_accept_out,
    output logic sdo_out,
    output logic sdo_oe_n_out,
    output logic fault_flag_n_out,
    output logic fault_flag_oe_n_out,
    output logic status_flag_n_out,
    output logic status_flag_oe_n_out
);

    function automatic logic hits(input logic [15:0] cmd,
                                  input logic [1:0] code);
        hits = !cmd[`SPCFG_BIT_ZERO] && !cmd[`SPCFG_BIT_NULL] &&
               cmd[`SPCFG_ADDR_HI:`SPCFG_ADDR_LO] == code;
    endfunction

    spcfg_pins_t pins_in;
    spcfg_pins_t sync_a;
    spcfg_pins_t sync_b;
    logic sclk_d;
    spcfg_state_t state;
    logic [3:0] bit_cnt;
    logic whole;
    logic [15:0] shift_in;
    logic [15:0] shift_out;
    logic [5:0] gate_request;
    logic [5:0] fault_reaction_mode;
    logic [5:0] retry_time_and_threshold;
    logic [5:0] flag_feedback_mask;
    logic fault_flag;
    logic status_flag;
    logic cs_fall;
    logic cs_rise;
    logic frame_ok;
    logic sclk_rise;
    logic sclk_fall;
    logic [5:0] cmd_data;
    logic [5:0] next_mask;

    assign pins_in = '{cs_n: chip_select_n_in, sclk: sclk_in,
                       sdi: sdi_in, ena_soft: soft_reset_enable_in,
                       ena_out: output_enable_in, par: parallel_in};

    // Pins leave the link's domain; two stages before any logic reads them
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            sync_a <= '{cs_n: 1'b1, default: '0};
            sync_b <= '{cs_n: 1'b1, default: '0};
            sclk_d <= 1'b0;
        end else begin
            sync_a <= pins_in;
            sync_b <= sync_a;
            sclk_d <= sync_b.sclk;
        end
    end

    assign sclk_rise = sync_b.sclk && !sclk_d;
    assign sclk_fall = !sync_b.sclk && sclk_d;
    assign cs_fall = state == SPCFG_IDLE && !sync_b.cs_n;
    assign cs_rise = state == SPCFG_SHIFT && sync_b.cs_n;
    assign frame_ok = cs_rise && whole && bit_cnt == 4'h0;
    assign cmd_data = shift_in[`SPCFG_DATA_HI:0];

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state <= SPCFG_IDLE;
        end else begin
            case (state)
                SPCFG_IDLE: begin
                    if (!sync_b.cs_n) begin
                        state <= SPCFG_SHIFT;
                    end
                end
                SPCFG_SHIFT: begin
                    if (sync_b.cs_n) begin
                        state <= SPCFG_IDLE;
                    end
                end
                default: begin
                    state <= SPCFG_IDLE;
                end
            endcase
        end
    end

    // Bit counter wraps every sixteen clocks; whole marks a full word seen
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            bit_cnt <= 4'h0;
            whole <= 1'b0;
            shift_in <= 16'h0000;
        end else if (cs_fall) begin
            bit_cnt <= 4'h0;
            whole <= 1'b0;
        end else if (state == SPCFG_SHIFT && !sync_b.cs_n && sclk_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == 4'hf) begin
                whole <= 1'b1;
            end
            shift_in <= {shift_in[14:0], sync_b.sdi};
        end
    end

    // Reply loads at select fall, next bit presented on each falling clock
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            shift_out <= 16'h0000;
            sdo_oe_n_out <= 1'b1;
        end else if (cs_fall) begin
            shift_out <= {`SPCFG_REPLY_PAD, fault_code_in};
            sdo_oe_n_out <= 1'b0;
        end else if (cs_rise) begin
            sdo_oe_n_out <= 1'b1;
        end else if (state == SPCFG_SHIFT && sclk_fall) begin
            shift_out <= {shift_out[14:0], 1'b0};
        end
    end

    assign sdo_out = shift_out[15];

    // Soft reset clears gate requests and holds off new ones
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            gate_request <= `SPCFG_REG_RESET;
        end else if (!sync_b.ena_soft) begin
            gate_request <= `SPCFG_REG_RESET;
        end else if (frame_ok && hits(shift_in, `SPCFG_ADDR_GATE)) begin
            gate_request <= cmd_data;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            fault_reaction_mode <= `SPCFG_REG_RESET;
        end else if (frame_ok && hits(shift_in, `SPCFG_ADDR_MODE)) begin
            fault_reaction_mode <= cmd_data;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            retry_time_and_threshold <= `SPCFG_REG_RESET;
        end else if (frame_ok && hits(shift_in, `SPCFG_ADDR_RETRY)) begin
            retry_time_and_threshold <= cmd_data;
        end
    end

    always_comb begin
        next_mask = flag_feedback_mask;
        if (frame_ok && hits(shift_in, `SPCFG_ADDR_MASK)) begin
            next_mask = cmd_data;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            flag_feedback_mask <= `SPCFG_REG_RESET;
        end else begin
            flag_feedback_mask <= next_mask;
        end
    end

    // Gate equation; reset stands in for the power-on qualifier
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            gate_drive_out <= 6'h00;
        end else begin
            gate_drive_out <= {6{sync_b.ena_soft && sync_b.ena_out}} &
                              ~shorted_load_state_in &
                              (sync_b.par | gate_request);
        end
    end

    // The flag is judged at select rise with the old mask ANDed with the
    // new one: a cleared bit drops at once, a set bit waits a frame
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            fault_flag <= 1'b0;
        end else if (!sync_b.ena_soft || cs_fall) begin
            fault_flag <= 1'b0;
        end else if (cs_rise) begin
            fault_flag <= |(fault_detect_in & flag_feedback_mask &
                            next_mask);
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            status_flag <= 1'b0;
        end else begin
            status_flag <= sync_b.ena_soft &&
                           |(drain_feedback_in & flag_feedback_mask);
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cmd_accept_out <= 1'b0;
        end else begin
            cmd_accept_out <= frame_ok;
        end
    end

    assign fault_flag_n_out = 1'b0;
    assign fault_flag_oe_n_out = !fault_flag;
    assign status_flag_n_out = 1'b0;
    assign status_flag_oe_n_out = !status_flag;

    assign config_out = '{
        latch_mode: fault_reaction_mode,
        retry_hi: retry_time_and_threshold[5],
        retry_lo: retry_time_and_threshold[2],
        thresh_hi: retry_time_and_threshold[4:3],
        thresh_lo: retry_time_and_threshold[1:0],
        flag_mask: flag_feedback_mask
    };

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    sequence frame_end_s;
        frame_ok;
    endsequence

    sequence mask_rise_s;
        frame_end_s ##0 |(~flag_feedback_mask & next_mask);
    endsequence

    reset_clears_a: assert property (disable iff (1'b0)
        sys_rst_in |=> gate_request == 6'h00 &&
        fault_reaction_mode == 6'h00 && flag_feedback_mask == 6'h00)
        else $error("Registers not cleared by reset");

    gate_soft_clear_a: assert property (
        !sync_b.ena_soft |=> gate_request == 6'h00)
        else $error("Gate request survives soft reset");

    gate_qualify_a: assert property (
        (!sync_b.ena_soft || !sync_b.ena_out) |=> gate_drive_out == 6'h00)
        else $error("Gate on while disabled");

    gate_write_a: assert property (
        frame_end_s ##0 hits(shift_in, `SPCFG_ADDR_GATE) ##0 sync_b.ena_soft
        |=> gate_request == $past(cmd_data))
        else $error("Gate write lost");

    mode_write_a: assert property (
        frame_end_s ##0 hits(shift_in, `SPCFG_ADDR_MODE) |=>
        fault_reaction_mode == $past(cmd_data))
        else $error("Mode write lost");

    retry_write_a: assert property (
        frame_end_s ##0 hits(shift_in, `SPCFG_ADDR_RETRY) |=>
        retry_time_and_threshold == $past(cmd_data))
        else $error("Retry and threshold write lost");

    mask_write_a: assert property (
        frame_end_s ##0 hits(shift_in, `SPCFG_ADDR_MASK) |=>
        flag_feedback_mask == $past(cmd_data))
        else $error("Mask write lost");

    null_frame_a: assert property (
        cs_rise && shift_in[`SPCFG_BIT_NULL] |=>
        $stable(fault_reaction_mode) && $stable(flag_feedback_mask) &&
        $stable(retry_time_and_threshold))
        else $error("Null command changed a register");

    frame_error_a: assert property (
        cs_rise && !(whole && bit_cnt == 4'h0) |=>
        $stable(fault_reaction_mode) && $stable(flag_feedback_mask))
        else $error("Partial frame accepted");

    accept_pulse_a: assert property (
        frame_ok |=> cmd_accept_out ##1 !cmd_accept_out)
        else $error("Accept pulse wrong");

    fault_mask_lag_a: assert property (
        mask_rise_s ##0 ((fault_detect_in & ~flag_feedback_mask) != 6'h00)
        ##0 ((fault_detect_in & flag_feedback_mask) == 6'h00)
        |=> !fault_flag)
        else $error("Fault flag followed new mask too early");

    status_follow_a: assert property (
        frame_end_s ##1 sync_b.ena_soft
        |=> status_flag == |($past(drain_feedback_in) & flag_feedback_mask))
        else $error("Status flag not following mask");

    flag_soft_clear_a: assert property (
        !sync_b.ena_soft |=> !fault_flag && !status_flag)
        else $error("Flag survives soft reset");

    reply_pad_a: assert property (
        cs_fall |=> shift_out[15:12] == 4'h0 && !sdo_oe_n_out)
        else $error("Reply top bits not zero");

    thresh_map_a: assert property (
        config_out.thresh_lo == retry_time_and_threshold[1:0] &&
        config_out.retry_hi == retry_time_and_threshold[5])
        else $error("Threshold field mapping wrong");

endmodule

// ===== tb/spcfg_host.sv
// SPI host model: mode 0 frames of 1 to 32 bits, MSB first.
// Assumes the device samples on sclk rise and shifts out on sclk fall.
`timescale 1ns/1ps
module spcfg_host (
    input wire logic sdo_in,
    output logic cs_n_out,
    output logic sclk_out,
    output logic sdi_out
);
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        sdi_out = 1'b0;
    end
    // Free bit count so that broken frames can be sent on purpose
    task automatic frame(input logic [31:0] cmd, input int n,
                         output logic [15:0] rx);
        rx = 16'h0000;
        cs_n_out = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            sdi_out = cmd[i];
            #62.5 sclk_out = 1'b1;
            rx = {rx[14:0], sdo_in};
            #62.5 sclk_out = 1'b0;
        end
        #62.5 cs_n_out = 1'b1;
        // Pull-down on the data pin once the frame is over
        sdi_out = 1'b0;
        #200;
    endtask
endmodule

// ===== tb/spcfg_regs_bench.sv
// Self-checking bench of the serial configuration register block.
// Assumes the host model drives the link pins asynchronously.
`timescale 1ns/1ps
module spcfg_regs_bench;
    import spcfg_pkg::*;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic soft_en = 1'b1;
    logic out_en = 1'b1;
    logic [5:0] par = 6'h00;
    logic [5:0] short = 6'h00;
    logic [5:0] drain = 6'h00;
    logic [5:0] fdet = 6'h00;
    logic [11:0] fcode = 12'h000;
    logic [5:0] gate;
    spcfg_cfg_t cfg;
    spcfg_cfg_t exp_cfg;
    logic [5:0] exp_gate;
    logic accept, sdo, sdo_oe_n, fflag, fflag_oe_n, sflag, sflag_oe_n;
    logic cs_n, sclk, sdi;
    logic [15:0] rx;
    logic [5:0] d;
    int n_errors = 0;
    int checks_done = 0;
    int n_accept = 0;
    int exp_accept = 0;
    always #2 clk_in = ~clk_in;
    // Accept is a one-cycle pulse; the falling edge sees it exactly once
    always @(negedge clk_in) begin
        if (accept === 1'b1)
            n_accept++;
    end
    spcfg_regs dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .chip_select_n_in(cs_n), .sclk_in(sclk), .sdi_in(sdi),
        .soft_reset_enable_in(soft_en), .output_enable_in(out_en),
        .parallel_in(par), .shorted_load_state_in(short),
        .drain_feedback_in(drain), .fault_detect_in(fdet),
        .fault_code_in(fcode), .gate_drive_out(gate), .config_out(cfg),
        .cmd_accept_out(accept), .sdo_out(sdo), .sdo_oe_n_out(sdo_oe_n),
        .fault_flag_n_out(fflag), .fault_flag_oe_n_out(fflag_oe_n),
        .status_flag_n_out(sflag), .status_flag_oe_n_out(sflag_oe_n));
    spcfg_host host (.sdo_in(sdo), .cs_n_out(cs_n), .sclk_out(sclk),
        .sdi_out(sdi));
    task automatic chk(input string name, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask
    function automatic spcfg_cfg_t apply(spcfg_cfg_t c, logic [1:0] a,
                                         logic [5:0] v);
        case (a)
            2'h1: c.latch_mode = v;
            2'h2: {c.retry_hi, c.thresh_hi, c.retry_lo, c.thresh_lo} = v;
            2'h3: c.flag_mask = v;
            default: ;
        endcase
        return c;
    endfunction
    // Junk in bits 11:6 must never reach a register
    task automatic wr(input logic [1:0] a, input logic [5:0] v);
        logic [5:0] junk;
        junk = 6'($urandom);
        @(negedge clk_in);
        fcode = 12'($urandom);
        host.frame({16'h0000, 2'b00, a, junk, v}, 16, rx);
        chk("reply", {4'h0, fcode}, rx);
        if (a == 2'h0)
            exp_gate = v;
        exp_cfg = apply(exp_cfg, a, v);
        exp_accept++;
    endtask
    task automatic cmp_all();
        chk("config", exp_cfg, cfg);
        chk("gate", exp_gate & ~short, gate);
        chk("sdo released", 1'b1, sdo_oe_n);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        results();
    end
    initial begin
        void'($urandom(32'h16d349ca));
        repeat (8) @(negedge clk_in);
        sys_rst_in = 1'b0;
        repeat (8) @(negedge clk_in);
        exp_cfg = '0;
        exp_gate = 6'h00;
        chk("reset config", 18'h0_0000, cfg);
        chk("reset gate", 6'h00, gate);
        chk("reset flags", 2'b11, {fflag_oe_n, sflag_oe_n});
        chk("flag pins", 2'b00, {fflag, sflag});
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            wr(2'(i % 4), (i < 4) ? 6'h3f : 6'($urandom));
            cmp_all();
        end
        $display("test writes done");
        @(negedge clk_in);
        short = 6'($urandom);
        repeat (8) @(negedge clk_in);
        cmp_all();
        out_en = 1'b0;
        repeat (8) @(negedge clk_in);
        chk("gate disabled", 6'h00, gate);
        out_en = 1'b1;
        short = 6'h00;
        wr(2'h0, 6'h3f);
        soft_en = 1'b0;
        repeat (8) @(negedge clk_in);
        chk("gate soft reset", 6'h00, gate);
        soft_en = 1'b1;
        exp_gate = 6'h00;
        repeat (8) @(negedge clk_in);
        cmp_all();
        $display("test gate qualify done");
        d = 6'($urandom);
        host.frame({16'h0000, 2'b01, d, 8'h3e}, 16, rx);
        exp_accept++;
        // Would write the mask if a short frame were wrongly taken
        host.frame({17'h0_0000, 15'h3015}, 15, rx);
        cmp_all();
        host.frame({16'hffff, 2'b00, 2'h3, 6'h00, 6'h2a}, 32, rx);
        exp_accept++;
        exp_cfg = apply(exp_cfg, 2'h3, 6'h2a);
        cmp_all();
        $display("test null and frames done");
        wr(2'h3, 6'h00);
        @(negedge clk_in);
        drain = 6'h01;
        fdet = 6'h01;
        wr(2'h3, 6'h01);
        chk("status on set", 1'b0, sflag_oe_n);
        chk("fault on set", 1'b1, fflag_oe_n);
        host.frame({16'h0000, 16'h4000}, 16, rx);
        exp_accept++;
        chk("fault next frame", 1'b0, fflag_oe_n);
        wr(2'h3, 6'h00);
        chk("flags on clear", 2'b11, {fflag_oe_n, sflag_oe_n});
        $display("test flags done");
        chk("accepts", exp_accept, n_accept);
        results();
    end
endmodule
